// File: include/swf_pkg.sv
// Shared constants and types for the self-write flash row controller.
// Assumes a single 125 MHz clock shared by the core-side and array-side ends.
// Overview of operation
// R1 - Any address reads one 14-bit word, no stall
// R2 - Addresses at 0x8000 up use configuration path
// R3 - Latch-only loads latch; plain write commits row
// R4 - Host unlocks with interrupts masked; latch no stall
// R5 - Row write halts fetch until programming done
// R6 - Interrupts during stall held, served after resume
// R7 - Erase clears one row, offset bits ignored
// R8 - Erase follows unlock, then stalls for cycle
// R9 - Erased row words read back 0x3fff
// R10 - Host erases only when bits must rise
// R11 - Programming only clears bits, never sets them
// R12 - Words latched in any order, no sequence
// R13 - Self-timed cycle about 2 ms, under 2.5 ms
// R14 - Stall equal for one word or full row
// R15 - High-endurance region keeps low byte only
// R16 - Row size parameter; row from upper address
package swf_pkg;
  localparam int WORD_W = 14;
  localparam int ADDR_W = 16;
  localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3fff;
  localparam logic [ADDR_W-1:0] CFG_BASE = 16'h8000;
  localparam int ROW_WORDS = 32;
  localparam int MAIN_WORDS = 8192;
  localparam int CFG_WORDS = 16;
  localparam int HEF_WORDS = 128;
  localparam int HEF_BYTE_W = 8;
  localparam int CLK_MHZ = 125;
  localparam int CYCLE_TIME_US = 2000;
  localparam int CYCLE_CNT = CYCLE_TIME_US * CLK_MHZ;
  localparam int CMD_W = 3;
  localparam logic [CMD_W-1:0] CMD_READ = 3'h0;
  localparam logic [CMD_W-1:0] CMD_LATCH = 3'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE = 3'h2;
  localparam logic [CMD_W-1:0] CMD_ERASE = 3'h3;
  localparam logic [CMD_W-1:0] CMD_UNLOCK = 3'h4;
  typedef enum logic [2:0]
  {
    SWF_IDLE = 3'b001,
    SWF_PROG = 3'b010,
    SWF_ERASE = 3'b100
  } swf_state_e;
endpackage : swf_pkg

// File: include/swf_link_if.sv
// Request and answer link between the core-side sequencer and the flash array end.
// Assumes both ends run on the same clock; the testbench binds it.
`timescale 1ns/1ps
interface swf_link_if;
  import swf_pkg::*;
  logic reqValid;
  logic [CMD_W-1:0] reqCmd;
  logic [ADDR_W-1:0] reqAddr;
  logic [WORD_W-1:0] reqData;
  logic rspValid;
  logic [WORD_W-1:0] rspData;
  logic busy;
  modport core (output reqValid, reqCmd, reqAddr, reqData, input rspValid, rspData, busy);
  modport array (input reqValid, reqCmd, reqAddr, reqData, output rspValid, rspData, busy);
endinterface : swf_link_if

// File: rtl/swf_array.sv
// Flash array end: word storage, configuration space, row latches and timed write/erase.
// Assumes the core end issues one request per cycle and honours busy.
`timescale 1ns/1ps
module swf_array
  import swf_pkg::*;
#(
  parameter int ROW_W = ROW_WORDS,
  parameter int MAIN_W = MAIN_WORDS,
  parameter int CYCLE_N = CYCLE_CNT,
  parameter int HEF_N = HEF_WORDS
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Link
  swf_link_if.array lnk,
  // Status
  output logic unlocked,
  output logic cycleDone
);
  localparam int OFS_W = $clog2(ROW_W);
  localparam int MA_W = $clog2(MAIN_W);
  localparam int CNT_W = $clog2(CYCLE_N + 1);
  logic [WORD_W-1:0] mainMem [MAIN_W];
  logic [WORD_W-1:0] cfgMem [CFG_WORDS];
  logic [WORD_W-1:0] rowLatch [ROW_W];
  logic [ROW_W-1:0] latchUsed;
  logic [MA_W-1:0] rowBase;
  logic [CNT_W-1:0] timer;
  swf_state_e state;
  logic isCfg;
  logic [MA_W-1:0] mainIdx;
  assign isCfg = lnk.reqAddr >= CFG_BASE; // R2
  assign mainIdx = lnk.reqAddr[MA_W-1:0];

  // Row start of any address inside it
  function automatic logic [MA_W-1:0] rowOf(input logic [MA_W-1:0] a);
    rowOf = {a[MA_W-1:OFS_W], {OFS_W{1'b0}}}; // R16
  endfunction : rowOf

  // Endurance region keeps only the low byte
  function automatic logic hefArea(input logic [MA_W-1:0] a);
    hefArea = a >= MA_W'(MAIN_W - HEF_N); // R15
  endfunction : hefArea

  // Reads answer one cycle later, never stalled
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      lnk.rspValid <= 1'b0;
      lnk.rspData <= '0;
    end
    else
    begin
      lnk.rspValid <= lnk.reqValid && lnk.reqCmd == CMD_READ; // R1
      if (lnk.reqValid && lnk.reqCmd == CMD_READ)
      begin
        if (isCfg)
          lnk.rspData <= cfgMem[lnk.reqAddr[$clog2(CFG_WORDS)-1:0]]; // R2
        else
          lnk.rspData <= mainMem[mainIdx]; // R1
      end
    end
  end

  // Unlock arms exactly one following latch, write or erase
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      unlocked <= 1'b0;
    else if (lnk.reqValid && state == SWF_IDLE)
    begin
      if (lnk.reqCmd == CMD_UNLOCK)
        unlocked <= 1'b1; // R4 R8
      else if (lnk.reqCmd != CMD_READ)
        unlocked <= 1'b0;
    end
  end

  // Sequencer and self-timed interval
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= SWF_IDLE;
      timer <= '0;
      lnk.busy <= 1'b0;
      cycleDone <= 1'b0;
      rowBase <= '0;
    end
    else
    begin
      cycleDone <= 1'b0;
      unique case (state)
        SWF_IDLE:
        begin
          if (lnk.reqValid && unlocked && !isCfg)
          begin
            if (lnk.reqCmd == CMD_WRITE)
            begin
              state <= SWF_PROG; // R3 R5
              lnk.busy <= 1'b1;
              timer <= CNT_W'(CYCLE_N); // R13 R14
              rowBase <= rowOf(mainIdx);
            end
            else if (lnk.reqCmd == CMD_ERASE)
            begin
              state <= SWF_ERASE; // R7 R8
              lnk.busy <= 1'b1;
              timer <= CNT_W'(CYCLE_N); // R13
              rowBase <= rowOf(mainIdx); // R7
            end
          end
        end
        SWF_PROG, SWF_ERASE:
        begin
          if (timer == CNT_W'(1))
          begin
            state <= SWF_IDLE;
            lnk.busy <= 1'b0; // R5
            cycleDone <= 1'b1;
          end
          timer <= timer - CNT_W'(1);
        end
      endcase
    end
  end

  // Latches load in any order; the committing word joins the row
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      latchUsed <= '0;
    else if (lnk.reqValid && unlocked && state == SWF_IDLE && !isCfg
             && (lnk.reqCmd == CMD_LATCH || lnk.reqCmd == CMD_WRITE))
      latchUsed[mainIdx[OFS_W-1:0]] <= 1'b1; // R12
    else if (state == SWF_PROG && timer == CNT_W'(1))
      latchUsed <= '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (lnk.reqValid && unlocked && state == SWF_IDLE && !isCfg
        && (lnk.reqCmd == CMD_LATCH || lnk.reqCmd == CMD_WRITE))
      rowLatch[mainIdx[OFS_W-1:0]] <= lnk.reqData; // R3 R4
  end

  // Array update at end of interval
  always_ff @(posedge clk_sys)
  begin
    if (timer == CNT_W'(1))
    begin
      for (int i = 0; i < ROW_W; i++)
      begin
        if (state == SWF_ERASE)
          mainMem[rowBase + MA_W'(i)] <= ERASED_WORD; // R9
        else if (state == SWF_PROG && latchUsed[i])
        begin
          if (hefArea(rowBase + MA_W'(i)))
            mainMem[rowBase + MA_W'(i)] <= mainMem[rowBase + MA_W'(i)]
              & {{(WORD_W-HEF_BYTE_W){1'b1}}, rowLatch[i][HEF_BYTE_W-1:0]}; // R15
          else
            mainMem[rowBase + MA_W'(i)] <= mainMem[rowBase + MA_W'(i)] & rowLatch[i]; // R11
        end
      end
    end
  end

  // Configuration words start erased
  initial
  begin
    for (int i = 0; i < CFG_WORDS; i++)
      cfgMem[i] = ERASED_WORD;
    for (int i = 0; i < MAIN_W; i++)
      mainMem[i] = ERASED_WORD;
  end
endmodule : swf_array

// File: rtl/swf_core.sv
// Core end: turns firmware commands into link requests, stalls fetch, defers interrupts.
// Assumes the array end answers reads next cycle and raises busy the cycle after a commit.
`timescale 1ns/1ps
module swf_core
  import swf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Firmware command
  input wire logic cmdValid,
  input wire logic [CMD_W-1:0] cmdKind,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [WORD_W-1:0] cmdData,
  output logic cmdReady,
  output logic rdValid,
  output logic [WORD_W-1:0] rdData,
  // Interrupts
  input wire logic irqIn,
  output logic irqOut,
  output logic irqMasked,
  output logic fetchStall,
  // Link
  swf_link_if.core lnk
);
  logic pend;
  logic commitWait;
  logic isCommit;
  logic armed;
  logic goCommit;
  assign isCommit = cmdValid && cmdReady && (cmdKind == CMD_WRITE || cmdKind == CMD_ERASE);
  // Only an armed commit into the main array starts a cycle
  assign goCommit = isCommit && armed && cmdAddr < CFG_BASE;

  // Mirror of the array end's unlock, consumed by any non-read
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      armed <= 1'b0;
    else if (cmdValid && cmdReady && cmdKind != CMD_READ)
      armed <= cmdKind == CMD_UNLOCK; // R4 R8
  end

  // Forward one request per accepted command
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      lnk.reqValid <= 1'b0;
      lnk.reqCmd <= CMD_READ;
      lnk.reqAddr <= '0;
      lnk.reqData <= '0;
    end
    else
    begin
      lnk.reqValid <= cmdValid && cmdReady; // R12
      if (cmdValid && cmdReady)
      begin
        lnk.reqCmd <= cmdKind;
        lnk.reqAddr <= cmdAddr;
        lnk.reqData <= cmdData;
      end
    end
  end

  // Ready drops while a commit is in flight or the array is busy
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      commitWait <= 1'b0;
      cmdReady <= 1'b1;
      fetchStall <= 1'b0;
    end
    else
    begin
      // Bridge the gap until busy is seen, so the stall has no hole
      if (goCommit)
        commitWait <= 1'b1;
      else if (lnk.busy)
        commitWait <= 1'b0;
      cmdReady <= !(isCommit || commitWait || lnk.busy);
      fetchStall <= goCommit || commitWait || lnk.busy; // R5 R8
    end
  end

  // Unlock masks interrupts until the next accepted command, a read included
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irqMasked <= 1'b0;
    else if (cmdValid && cmdReady)
      irqMasked <= cmdKind == CMD_UNLOCK; // R4 R8
  end

  // Interrupts held while stalled or masked, set wins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pend <= 1'b0;
      irqOut <= 1'b0;
    end
    else
    begin
      irqOut <= 1'b0;
      if (fetchStall || irqMasked)
        pend <= pend | irqIn; // R6
      else
      begin
        irqOut <= pend | irqIn; // R6
        pend <= 1'b0;
      end
    end
  end

  // Read answer back to firmware
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdValid <= 1'b0;
      rdData <= '0;
    end
    else
    begin
      rdValid <= lnk.rspValid; // R1
      if (lnk.rspValid)
        rdData <= lnk.rspData;
    end
  end
endmodule : swf_core

// File: tb/swf_link_chk.sv
// Checker on the link between core and array ends.
// Assumes one clock and the array cycle length passed in.
`timescale 1ns/1ps
module swf_link_chk
  import swf_pkg::*;
#(
  parameter int CYCLE_N = CYCLE_CNT
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Link
  input wire logic reqValid,
  input wire logic [CMD_W-1:0] reqCmd,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic rspValid,
  input wire logic [WORD_W-1:0] rspData,
  input wire logic busy
);
  int busyCnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      busyCnt <= 0;
    else
      busyCnt <= busy ? busyCnt + 1 : 0;
  end
  a_read_answer: assert property (reqValid && reqCmd == CMD_READ |=> rspValid)
    else $error("read not answered");
  a_rsp_cause: assert property (rspValid |-> $past(reqValid && reqCmd == CMD_READ))
    else $error("answer without read");
  a_rsp_held: assert property (!rspValid |-> $stable(rspData))
    else $error("read data moved");
  a_busy_cause: assert property ($rose(busy) |->
    $past(reqValid && (reqCmd == CMD_WRITE || reqCmd == CMD_ERASE)))
    else $error("busy without commit");
  a_busy_quiet: assert property (busy |-> !reqValid)
    else $error("request while busy");
  a_busy_hold: assert property ($rose(busy) |=> busy [*8])
    else $error("busy too short");
  a_busy_length: assert property ($fell(busy) |-> busyCnt == CYCLE_N)
    else $error("busy length wrong");
  a_cfg_ignored: assert property (reqValid && reqCmd != CMD_READ &&
    reqAddr >= CFG_BASE |=> !busy)
    else $error("config space written");
endmodule : swf_link_chk

// File: tb/self_write_flash_row_controller_bench.sv
// Bench joining core and array ends, with a word model of the array.
// Assumes a shortened write cycle and an erased array after reset.
`timescale 1ns/1ps
module self_write_flash_row_controller_bench;
  import swf_pkg::*;
  localparam int CYC = 20;
  logic clk_sys = 0;
  logic nrst = 0;
  logic cmdValid = 0;
  logic [CMD_W-1:0] cmdKind = '0;
  logic [ADDR_W-1:0] cmdAddr = '0;
  logic [WORD_W-1:0] cmdData = '0;
  logic irqIn = 0;
  logic cmdReady, rdValid, irqOut, irqMasked, fetchStall, unlocked, cycleDone;
  logic [WORD_W-1:0] rdData;
  logic [15:0] rnd = 16'h38eb;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int nIrq = 0;
  int mem[int];
  int lat[int];
  bit ul = 0;
  swf_link_if lnk();
  swf_core u_swf_core (.clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
    .rdValid(rdValid), .rdData(rdData), .irqIn(irqIn), .irqOut(irqOut),
    .irqMasked(irqMasked), .fetchStall(fetchStall), .lnk(lnk));
  swf_array #(.CYCLE_N(CYC)) u_swf_array (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk),
    .unlocked(unlocked), .cycleDone(cycleDone));
  swf_link_chk #(.CYCLE_N(CYC)) chk (.clk_sys(clk_sys), .nrst(nrst),
    .reqValid(lnk.reqValid), .reqCmd(lnk.reqCmd), .reqAddr(lnk.reqAddr),
    .rspValid(lnk.rspValid), .rspData(lnk.rspData), .busy(lnk.busy));
  always #4 clk_sys = ~clk_sys;
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic int rd(int a);
    return mem.exists(a) ? mem[a] : 'h3fff;
  endfunction : rd
  task automatic fail(string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk_word(logic [WORD_W-1:0] got, int exp);
    checks_done++;
    if (got !== WORD_W'(exp))
      fail("read data");
  endtask : chk_word
  task automatic chk_count(int got, int lo, int hi, string m);
    checks_done++;
    if (got < lo || got > hi)
      fail(m);
  endtask : chk_count
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic op(logic [CMD_W-1:0] k, logic [ADDR_W-1:0] a, logic [WORD_W-1:0] d);
    int n;
    bit ok;
    bit st;
    ok = ul && a < CFG_BASE;
    st = ok && (k == CMD_WRITE || k == CMD_ERASE);
    @(posedge clk_sys);
    cmdValid <= 1;
    cmdKind <= k;
    cmdAddr <= a;
    cmdData <= d;
    do @(negedge clk_sys); while (cmdReady !== 1'b1);
    @(posedge clk_sys);
    cmdValid <= 0;
    if (k != CMD_READ)
      ul = (k == CMD_UNLOCK);
    if (ok && (k == CMD_LATCH || k == CMD_WRITE))
      lat[a] = d;
    if (ok && k == CMD_WRITE)
    begin
      foreach (lat[i])
        mem[i] = rd(i) & (i >= MAIN_WORDS - HEF_WORDS ? lat[i] | 'h3f00 : lat[i]);
      lat.delete();
    end
    if (ok && k == CMD_ERASE)
      for (int i = 0; i < ROW_WORDS; i++)
        mem[(a & ~(ROW_WORDS - 1)) + i] = 'h3fff;
    n = 0;
    if (k == CMD_READ)
    begin
      while (rdValid !== 1'b1 && n < 8)
      begin
        @(negedge clk_sys);
        n++;
      end
      chk_word(rdData, rd(a));
    end
    else
    begin
      repeat (CYC + 8) @(negedge clk_sys) n += (fetchStall === 1'b1);
      chk_count(n, st ? CYC : 0, st ? CYC + 3 : 0, "stall");
    end
  endtask : op
  task automatic read_row(int b);
    for (int i = 0; i < ROW_WORDS; i += 3)
      op(CMD_READ, b + i, 0);
    $display("test done at row %0d", b);
  endtask : read_row
  always @(negedge clk_sys)
  begin
    cyc++;
    if (irqOut === 1'b1 && fetchStall === 1'b1)
      fail("irq during stall");
    if (irqOut === 1'b1)
      nIrq++;
    if (cyc == 20000)
    begin
      fail("timeout");
      finish_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1;
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      op(CMD_READ, i[0] ? CFG_BASE + rnd[3:0] : rnd & 16'h1f7f, 0);
    end
    op(CMD_LATCH, 16'h0043, 14'h0000);
    for (int p = 0; p < 2; p++)
      for (int j = 8; j >= 0; j -= 4)
      begin
        rnd = lfsr(rnd);
        op(CMD_UNLOCK, 0, 0);
        op(j ? CMD_LATCH : CMD_WRITE, 16'h0040 + j, rnd[13:0]);
      end
    read_row(16'h0040);
    op(CMD_UNLOCK, 0, 0);
    op(CMD_WRITE, CFG_BASE + 1, 14'h0000);
    op(CMD_READ, CFG_BASE + 1, 0);
    op(CMD_UNLOCK, 0, 0);
    op(CMD_WRITE, 16'h1fc0, 14'h0000);
    op(CMD_READ, 16'h1fc0, 0);
    chk_count(nIrq, 0, 0, "early irq");
    op(CMD_UNLOCK, 0, 0);
    fork
      op(CMD_ERASE, 16'h0051, 0);
      repeat (6) @(posedge clk_sys) irqIn <= 1;
    join
    irqIn <= 0;
    chk_count(nIrq, 1, 1000, "irq lost");
    read_row(16'h0040);
    finish_test();
  end
endmodule : self_write_flash_row_controller_bench
